// [shared/dpw_consts.svh]
`ifndef DPW_CONSTS_SVH
`define DPW_CONSTS_SVH
// Overview of operation
// [R1] Array access: port select low, flag select high; flag access: the reverse.
// [R2] Device writes the array only while port select and write strobe are both low.
// [R3] Address changes only while write strobe, port select or both byte selects are high.
// [R4] Select going active with or after strobe low keeps device data pins floating.
// [R5] Never drive write data while the device may still drive its pins.
// [R6] With output enable low, strobe width covers float delay plus data set-up.
// [R7] Select stays active at least the enable-to-write-end minimum.
// [R8] Address is stable at least the address-to-write-end minimum before write end.
// [R9] Write data is valid at least the data-to-write-end minimum before write end.
// [R10] Write data is held at least data_hold_min after the write ends.
// [R11] Device floats its data outputs within the float delay after strobe low.
// [R12] Device may drive its outputs again no sooner than 0 ns after write end.
// [R13] Wait at least 5 ns after a flag write before reading that flag.
// [R14] Port select or both byte selects stay high across a flag write and read.
// [R15] A flag read returns the flag value on all sixteen data lines.
// [R16] Flag writes from two ports resolve in order only when 5 ns apart.
// [R17] Array writes update only byte lanes whose byte select is low.

// Slowest-grade minimums in ns, covering every grade.
`define DPW_EW_NS      45
`define DPW_AW_NS      45
`define DPW_WP_NS      40
`define DPW_DW_NS      30
`define DPW_WZ_NS      25
`define DPW_DH_NS      0
`define DPW_SWRD_NS    5
`define DPW_SPS_NS     5
`define DPW_CLK_NS     10
`define DPW_CYC_UP(ns) (((ns) + `DPW_CLK_NS - 1) / `DPW_CLK_NS)
`define DPW_ONE(x)     (((x) < 1) ? 1 : (x))
`define DPW_SETUP_CYC  `DPW_ONE(`DPW_CYC_UP(`DPW_WZ_NS))
`define DPW_PULSE_CYC  `DPW_ONE(`DPW_CYC_UP(`DPW_WP_NS))
`define DPW_DATA_CYC   `DPW_ONE(`DPW_CYC_UP(`DPW_DW_NS))
`define DPW_HOLD_CYC   `DPW_ONE(`DPW_CYC_UP(`DPW_DH_NS))
`define DPW_GAP_CYC    `DPW_ONE(`DPW_CYC_UP(`DPW_SWRD_NS))
`define DPW_EW_CYC     `DPW_ONE(`DPW_CYC_UP(`DPW_EW_NS))
`define DPW_AW_CYC     `DPW_ONE(`DPW_CYC_UP(`DPW_AW_NS))
`define DPW_CNT_W      3
`define DPW_AGE_W      4
`define DPW_ONES16     16'hFFFF
`define DPW_ZERO16     16'h0000
`endif

// [shared/dpw_pkg.sv]
package dpw_pkg;
	typedef enum logic [2:0] {
		DPW_IDLE,
		DPW_SETUP,
		DPW_STROBE,
		DPW_HOLD,
		DPW_GAP,
		DPW_READ
	} dpw_state_t;
endpackage

// [rtl/dpw_host.sv]
`timescale 1ns/1ps
`include "dpw_consts.svh"
module dpw_host
	import dpw_pkg::*;
#(
	parameter int ADDR_W = 14,
	parameter int DATA_W = 16
) (
	input  wire logic              clk_in,          // 100 MHz clock
	input  wire logic              rst_n_in,        // Async reset, low
	input  wire logic              req_valid_in,    // Request strobe
	input  wire logic              req_flag_in,     // 1: flag, 0: array
	input  wire logic              req_read_in,     // 1: read, 0: write
	input  wire logic [ADDR_W-1:0] req_addr_in,     // Word or flag address
	input  wire logic [DATA_W-1:0] req_wdata_in,    // Write data
	input  wire logic [1:0]        req_lanes_in,    // [1] high, [0] low lane
	input  wire logic [DATA_W-1:0] mem_data_in,     // Data pins, sampled
	output logic                   req_ready_out,   // Idle, may take request
	output logic                   rsp_valid_out,   // Read data pulse
	output logic [DATA_W-1:0]      rsp_data_out,    // Read data
	output logic                   port_sel_n_out,  // Array select
	output logic                   flag_select_n_out, // Flag select
	output logic                   wr_n_out,        // Write strobe
	output logic                   oe_n_out,        // Output enable
	output logic                   high_byte_sel_n_out, // High byte lane
	output logic                   low_byte_sel_n_out,  // Low byte lane
	output logic [ADDR_W-1:0]      mem_addr_out,    // Address pins
	output logic [DATA_W-1:0]      mem_data_out,    // Data pins, driven
	output logic                   mem_data_oe_out  // High while driving
);
	// ---------------------------------------------------------------
	// Sequencer
	// ---------------------------------------------------------------
	dpw_state_t                 state_q;
	logic [`DPW_CNT_W-1:0]      cnt_q;
	logic                       flag_q;
	logic                       read_q;
	logic                       after_wr_q;

	function automatic logic [`DPW_CNT_W-1:0] cyc(input int n);
		cyc = `DPW_CNT_W'(n - 1);
	endfunction

	wire logic cnt_done = (cnt_q == `DPW_CNT_W'(0));

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_q    <= DPW_IDLE;
			cnt_q      <= '0;
			flag_q     <= 1'b0;
			read_q     <= 1'b0;
			after_wr_q <= 1'b0;
		end else begin
			case (state_q)
				DPW_IDLE: begin
					after_wr_q <= 1'b0;
					if (req_valid_in) begin
						flag_q <= req_flag_in;
						read_q <= req_read_in;
						// Select goes active before the strobe falls. [R1] [R4]
						state_q <= DPW_SETUP;
						cnt_q   <= cyc(`DPW_SETUP_CYC);
					end
				end
				DPW_SETUP: begin
					if (cnt_done) begin
						state_q <= read_q ? DPW_READ : DPW_STROBE;
						// Strobe low spans pulse width and data set-up. [R6] [R9]
						cnt_q   <= read_q ? cyc(`DPW_DATA_CYC)
							: cyc(`DPW_PULSE_CYC);
					end else begin
						cnt_q <= cnt_q - 1'b1;
					end
				end
				DPW_STROBE: begin
					if (cnt_done) begin
						state_q <= DPW_HOLD;
						cnt_q   <= cyc(`DPW_HOLD_CYC);
					end else begin
						cnt_q <= cnt_q - 1'b1;
					end
				end
				DPW_HOLD: begin
					if (cnt_done) begin
						// A flag write waits before its read-back. [R13]
						state_q <= flag_q ? DPW_GAP : DPW_IDLE;
						cnt_q   <= cyc(`DPW_GAP_CYC);
					end else begin
						cnt_q <= cnt_q - 1'b1;
					end
				end
				DPW_GAP: begin
					if (cnt_done) begin
						// Read-back shows who won a near tie. [R16]
						state_q    <= DPW_READ;
						read_q     <= 1'b1;
						after_wr_q <= 1'b1;
						cnt_q      <= cyc(`DPW_DATA_CYC);
					end else begin
						cnt_q <= cnt_q - 1'b1;
					end
				end
				DPW_READ: begin
					if (cnt_done) begin
						state_q <= DPW_IDLE;
					end else begin
						cnt_q <= cnt_q - 1'b1;
					end
				end
				default: begin
					state_q <= DPW_IDLE;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Pin drive
	// ---------------------------------------------------------------
	wire logic active   = (state_q != DPW_IDLE);
	wire logic in_write = (state_q == DPW_SETUP && !read_q) ||
		state_q == DPW_STROBE || state_q == DPW_HOLD;
	wire logic start    = (state_q == DPW_IDLE) && req_valid_in;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			port_sel_n_out    <= 1'b1;
			flag_select_n_out <= 1'b1;
		end else if (start) begin
			port_sel_n_out    <= req_flag_in; // [R1]
			flag_select_n_out <= !req_flag_in; // [R1]
		end else if ((state_q == DPW_HOLD && !flag_q) ||
			(state_q == DPW_READ && cnt_done)) begin
			// Select stays held through the whole strobe, and a flag
			// select also through its read-back. [R7] [R14]
			port_sel_n_out    <= 1'b1;
			flag_select_n_out <= 1'b1;
		end
	end

	// The strobe is only low inside STROBE so it ends first. [R2]
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_n_out <= 1'b1;
		end else begin
			wr_n_out <= !((state_q == DPW_SETUP && cnt_done && !read_q) ||
				(state_q == DPW_STROBE && !cnt_done));
		end
	end

	// Output enable stays high while writing, so the device never drives
	// into our data. This costs a short strobe but is always safe. [R5]
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			oe_n_out <= 1'b1;
		end else begin
			oe_n_out <= !((state_q == DPW_SETUP && cnt_done && read_q) ||
				(state_q == DPW_GAP && cnt_done) ||
				(state_q == DPW_READ && !cnt_done));
		end
	end

	// Flag cycles keep both byte lanes high; array lanes follow request.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			high_byte_sel_n_out <= 1'b1;
			low_byte_sel_n_out  <= 1'b1;
		end else if (start) begin
			high_byte_sel_n_out <= req_flag_in || !req_lanes_in[1]; // [R14] [R17]
			low_byte_sel_n_out  <= req_flag_in || !req_lanes_in[0]; // [R14] [R17]
		end else if (!active) begin
			high_byte_sel_n_out <= 1'b1;
			low_byte_sel_n_out  <= 1'b1;
		end
	end

	// Address loads only at start, while port and flag selects are still high. [R3] [R8]
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			mem_addr_out <= '0;
		end else if (start) begin
			mem_addr_out <= req_addr_in;
		end
	end

	// Data drives from setup until one cycle after the strobe rises. [R10]
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			mem_data_out    <= '0;
			mem_data_oe_out <= 1'b0;
		end else begin
			if (start) begin
				mem_data_out <= req_wdata_in;
			end
			mem_data_oe_out <= (start && !req_read_in) ||
				(in_write && !(state_q == DPW_HOLD && cnt_done));
		end
	end

	// ---------------------------------------------------------------
	// Request and answer
	// ---------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			req_ready_out <= 1'b1;
			rsp_valid_out <= 1'b0;
			rsp_data_out  <= '0;
		end else begin
			req_ready_out <= !start && (!active ||
				(state_q == DPW_HOLD && cnt_done && !flag_q) ||
				(state_q == DPW_READ && cnt_done));
			rsp_valid_out <= state_q == DPW_READ && cnt_done;
			if (state_q == DPW_READ && cnt_done) begin
				// Flag state reads on all lines; bit 0 carries it. [R15]
				rsp_data_out <= flag_q ? {DATA_W{mem_data_in[0]}}
					: mem_data_in;
			end
		end
	end

	// ---------------------------------------------------------------
	// Check helpers
	// ---------------------------------------------------------------
	// Saturating ages measure the long minimums in a few bits, so no
	// check needs a long repetition. They never feed the pin logic.
	logic [`DPW_AGE_W-1:0]      sel_age_q;
	logic [`DPW_AGE_W-1:0]      load_age_q;

	function automatic logic [`DPW_AGE_W-1:0] age_step(
		input logic [`DPW_AGE_W-1:0] age
	);
		age_step = (&age) ? age : age + 1'b1;
	endfunction

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sel_age_q <= '0;
		end else if (port_sel_n_out && flag_select_n_out) begin
			sel_age_q <= '0;
		end else begin
			sel_age_q <= age_step(sel_age_q);
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			load_age_q <= '0;
		end else if (start) begin
			load_age_q <= '0;
		end else begin
			load_age_q <= age_step(load_age_q);
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	strobe_width_a: assert property ( // [R6]
		@(posedge clk_in) disable iff (!rst_n_in)
		$fell(wr_n_out) |-> !wr_n_out [*4])
		else $error("write strobe shorter than pulse minimum");
	sel_cover_a: assert property ( // [R1]
		@(posedge clk_in) disable iff (!rst_n_in)
		!wr_n_out |-> (port_sel_n_out != flag_select_n_out))
		else $error("select not valid during strobe");
	addr_stable_a: assert property ( // [R3]
		@(posedge clk_in) disable iff (!rst_n_in)
		!$stable(mem_addr_out) |-> $past(wr_n_out)
		&& $past(port_sel_n_out) && $past(flag_select_n_out))
		else $error("address moved during access");
	no_contend_a: assert property ( // [R5]
		@(posedge clk_in) disable iff (!rst_n_in)
		mem_data_oe_out |-> oe_n_out)
		else $error("data driven while device output enabled");
	data_hold_a: assert property ( // [R10]
		@(posedge clk_in) disable iff (!rst_n_in)
		$rose(wr_n_out) |-> mem_data_oe_out && $stable(mem_data_out))
		else $error("write data released with strobe");
	flag_lanes_a: assert property ( // [R14]
		@(posedge clk_in) disable iff (!rst_n_in)
		!flag_select_n_out |-> high_byte_sel_n_out
		&& low_byte_sel_n_out)
		else $error("byte lanes active in flag cycle");
	flag_gap_a: assert property ( // [R13]
		@(posedge clk_in) disable iff (!rst_n_in)
		$rose(wr_n_out) && !flag_select_n_out |-> oe_n_out [*2])
		else $error("flag read too soon after write");
	strobe_late_a: assert property ( // [R4]
		@(posedge clk_in) disable iff (!rst_n_in)
		$fell(wr_n_out) |-> $past(!port_sel_n_out || !flag_select_n_out))
		else $error("strobe fell before select");
	sel_long_a: assert property ( // [R7]
		@(posedge clk_in) disable iff (!rst_n_in)
		$rose(wr_n_out) |-> sel_age_q >= `DPW_AGE_W'(`DPW_EW_CYC))
		else $error("select shorter than enable-to-write-end minimum");
	addr_age_a: assert property ( // [R8]
		@(posedge clk_in) disable iff (!rst_n_in)
		$rose(wr_n_out) |-> load_age_q >= `DPW_AGE_W'(`DPW_AW_CYC))
		else $error("address not settled long enough before write end");
	data_age_a: assert property ( // [R9]
		@(posedge clk_in) disable iff (!rst_n_in)
		$rose(wr_n_out) |-> mem_data_oe_out
		&& load_age_q >= `DPW_AGE_W'(`DPW_DATA_CYC))
		else $error("write data not settled long enough before write end");
	oe_select_a: assert property ( // [R1]
		@(posedge clk_in) disable iff (!rst_n_in)
		!oe_n_out |-> (port_sel_n_out != flag_select_n_out))
		else $error("output enable with no access selected");
	sel_release_a: assert property ( // [R7]
		@(posedge clk_in) disable iff (!rst_n_in)
		$rose(port_sel_n_out) || $rose(flag_select_n_out)
		|-> $past(wr_n_out))
		else $error("select released while strobe low");
	readback_sel_a: assert property ( // [R14]
		@(posedge clk_in) disable iff (!rst_n_in)
		after_wr_q && state_q == DPW_READ |-> !flag_select_n_out
		&& port_sel_n_out)
		else $error("flag select dropped during read-back");
endmodule

// [dv/dpw_dev_model.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// One port of the dual-port memory with its flag
// ----------------------------------------------------------------
module dpw_dev_model (
	input  wire logic        clk_in,  // Only paces the idle pattern
	input  wire logic        psel_n,  // Array select
	input  wire logic        fsel_n,  // Flag select
	input  wire logic        wr_n,    // Write strobe
	input  wire logic        oe_n,    // Output enable
	input  wire logic [1:0]  lane_n,  // High, low byte select
	input  wire logic [13:0] addr,    // Address pins
	input  wire logic [15:0] din,     // Data from host
	output logic      [15:0] dout     // Data to host
);
	logic [15:0] cells [int];
	logic [15:0] cur;
	logic        flag_q = 1'b1;
	logic [15:0] last_q = 16'h0000;
	// Writes track the pins through the whole overlap, so the value
	// stored is the one present when the overlap ends.
	always @(psel_n, fsel_n, wr_n, lane_n, addr, din) begin
		cur = cells.exists(addr) ? cells[addr] : 16'h0000;
		if (!psel_n && fsel_n && !wr_n) begin
			if (!lane_n[1]) cur[15:8] = din[15:8];
			if (!lane_n[0]) cur[7:0] = din[7:0];
			cells[addr] = cur;
		end
		if (!fsel_n && psel_n && !wr_n) flag_q = din[0];
	end
	// A released bus shows a changing pattern, inverting every clock.
	always @(*) begin
		if (!oe_n && wr_n && !fsel_n) dout = {16{flag_q}};
		else if (!oe_n && wr_n && !psel_n)
			dout = cells.exists(addr) ? cells[addr] : 16'h0000;
		else dout = ~last_q;
	end
	always @(posedge clk_in) last_q <= dout;
endmodule

// [dv/tb.sv]
`timescale 1ns/1ps
`include "dpw_consts.svh"
module tb;
	logic        clk_in = 1'b0, rst_n_in = 1'b0, req_valid_in = 1'b0;
	logic        req_flag_in = 1'b0, req_read_in = 1'b0;
	logic [13:0] req_addr_in = 14'h0000, mem_addr_out, a_q;
	logic [15:0] req_wdata_in = 16'h0000, mem_data_in, rsp_data_out;
	logic [15:0] mem_data_out, v;
	logic [1:0]  req_lanes_in = 2'h0;
	logic        req_ready_out, rsp_valid_out, port_sel_n_out, oe_n_out;
	logic        flag_select_n_out, wr_n_out, mem_data_oe_out;
	logic        high_byte_sel_n_out, low_byte_sel_n_out;
	int          fail_count = 0, compares = 0, cycles = 0, pw = 0;
	logic [15:0] ref_mem [int];
	dpw_host uut (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.req_valid_in(req_valid_in), .req_flag_in(req_flag_in),
		.req_read_in(req_read_in), .req_addr_in(req_addr_in),
		.req_wdata_in(req_wdata_in), .req_lanes_in(req_lanes_in),
		.mem_data_in(mem_data_in), .req_ready_out(req_ready_out),
		.rsp_valid_out(rsp_valid_out), .rsp_data_out(rsp_data_out),
		.port_sel_n_out(port_sel_n_out), .wr_n_out(wr_n_out),
		.flag_select_n_out(flag_select_n_out), .oe_n_out(oe_n_out),
		.high_byte_sel_n_out(high_byte_sel_n_out),
		.low_byte_sel_n_out(low_byte_sel_n_out),
		.mem_addr_out(mem_addr_out), .mem_data_out(mem_data_out),
		.mem_data_oe_out(mem_data_oe_out));
	dpw_dev_model dev (.clk_in(clk_in), .psel_n(port_sel_n_out),
		.fsel_n(flag_select_n_out), .wr_n(wr_n_out), .oe_n(oe_n_out),
		.lane_n({high_byte_sel_n_out, low_byte_sel_n_out}),
		.addr(mem_addr_out), .din(mem_data_out), .dout(mem_data_in));
	initial forever #5 clk_in = ~clk_in;
	task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
			fail_count++;
		end
	endtask
	task automatic results;
		$display("mismatches %0d comparisons %0d", fail_count, compares);
		if (fail_count == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic op(logic f, logic r, logic [13:0] a, logic [15:0] d,
		logic [1:0] l);
		int n;
		n = 0;
		while (req_ready_out !== 1'b1) begin @(posedge clk_in); #1; end
		req_valid_in = 1'b1;
		req_flag_in = f;
		req_read_in = r;
		req_addr_in = a;
		req_wdata_in = d;
		req_lanes_in = l;
		@(posedge clk_in);
		#1 req_valid_in = 1'b0;
		while (n < 40 && ((f | r) ? rsp_valid_out : req_ready_out) !== 1'b1)
			begin @(posedge clk_in); #1; n++; end
		check("completion", 16'(n < 40), 16'h0001);
	endtask
	// --------------------------------------------------------------
	// Pin watch: sampled on the falling edge, where all is settled
	// --------------------------------------------------------------
	always @(negedge clk_in) begin
		cycles++;
		if (cycles == 20000) begin fail_count++; results; end
		if (wr_n_out === 1'b0) begin
			if (pw > 0) check("address", mem_addr_out, a_q);
			a_q = mem_addr_out;
			pw++;
			check("oe in write", oe_n_out, 1'b1);
			check("data drive", mem_data_oe_out, 1'b1);
			check("one select", port_sel_n_out ^ flag_select_n_out,
				16'h0001);
		end else if (pw > 0) begin
			check("pulse", 16'(pw >= `DPW_PULSE_CYC), 16'h0001);
			pw = 0;
		end
	end
	initial begin
		logic [13:0] a;
		logic [15:0] d;
		logic [1:0]  l;
		logic        r;
		void'($urandom(81021));
		repeat (3) @(posedge clk_in);
		#1 rst_n_in = 1'b1;
		for (int i = 0; i < 40; i++) begin
			a = 14'($urandom_range(7));
			d = 16'($urandom);
			l = 2'($urandom_range(3));
			r = 1'($urandom_range(1));
			op(1'b0, r, a, d, l);
			v = ref_mem.exists(a) ? ref_mem[a] : 16'h0000;
			if (r) check("array read", rsp_data_out, v);
			else begin
				if (l[1]) v[15:8] = d[15:8];
				if (l[0]) v[7:0] = d[7:0];
				ref_mem[a] = v;
			end
		end
		for (int k = 0; k < 4; k++) begin
			d = 16'($urandom) & 16'hFFFE | 16'(k & 1);
			op(1'b1, 1'b0, 14'(k), d, 2'h3);
			check("flag readback", rsp_data_out, {16{d[0]}});
			op(1'b1, 1'b1, 14'(k), 16'h0000, 2'h3);
			check("flag read", rsp_data_out, {16{d[0]}});
		end
		results;
	end
endmodule
